/* dv/bus_master_model.sv */
// behavioural memory controller facing the burst sram port
// assumes the bench calls its tasks just after a rising clock edge
`timescale 1ns/1ps
`include "sram_port_defines.svh"

module bus_master_model (
    // address and control
    output logic [`SRAM_ADDR_W-1:0] address,
    output logic read_write_select,
    output logic step_or_capture,
    output logic clock_gate_low,
    output logic [`SRAM_BYTES-1:0] byte_lane_strobes_n,
    // chip selects
    output logic chip_select_first_low,
    output logic [1:0] chip_select_high_and_second_low,
    // write data
    output logic [`SRAM_DATA_W-1:0] dq_in
);
    // ================================================================
    // idle at time zero: deselected, clock enabled
    initial begin
        address = 17'h00000;
        read_write_select = 1'b1;
        step_or_capture = 1'b0;
        clock_gate_low = 1'b0;
        byte_lane_strobes_n = 4'hf;
        chip_select_first_low = 1'b1;
        chip_select_high_and_second_low = 2'h1;
        dq_in = 36'h000000000;
    end

    // ================================================================
    // one enabled request; strobes follow the write direction
    task automatic drive(input logic sel, input logic step, input logic rw,
                         input logic [`SRAM_ADDR_W-1:0] a, input logic wr,
                         input logic [`SRAM_DATA_W-1:0] d,
                         input logic [`SRAM_BYTES-1:0] lanes_n = 4'h0);
        clock_gate_low = 1'b0;
        address = a;
        read_write_select = rw;
        step_or_capture = step;
        byte_lane_strobes_n = rw ? 4'hf : lanes_n;
        chip_select_first_low = !sel;
        chip_select_high_and_second_low = {sel, !sel};
        dq_in = wr ? d : ~dq_in;
    endtask

    // suspended cycle; address, rw, step and write data scrambled, strobes and chip selects kept
    task automatic hold_off();
        clock_gate_low = 1'b1;
        address = ~address;
        read_write_select = ~read_write_select;
        step_or_capture = ~step_or_capture;
        dq_in = ~dq_in;
    endtask
endmodule

/* dv/sync_burst_sram_port_tb.sv */
// self-checking bench for the burst sram port
// assumes bus_master_model drives the controller side
`timescale 1ns/1ps
`include "sram_port_defines.svh"

module sync_burst_sram_port_tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic lin = 1'b1;
    logic oe_n = 1'b0;
    logic [16:0] address;
    logic rw, step, gate, cs1_n;
    logic [3:0] be_n;
    logic [1:0] cs2;
    logic [35:0] dq_in, dq_out;
    logic dq_oe;
    logic [35:0] mem [0:131071];
    int failures = 0;
    int cmp_count = 0;

    // ================================================================
    // clock, model and design
    always #2.5 core_clk = ~core_clk;

    bus_master_model bus_master_model_i (.address(address), .read_write_select(rw),
        .step_or_capture(step), .clock_gate_low(gate), .byte_lane_strobes_n(be_n),
        .chip_select_first_low(cs1_n), .chip_select_high_and_second_low(cs2),
        .dq_in(dq_in));

    sync_burst_sram_port sync_burst_sram_port_i (.core_clk(core_clk), .rst(rst),
        .address(address), .read_write_select(rw), .step_or_capture(step),
        .clock_gate_low(gate), .byte_lane_strobes_n(be_n), .linear_order_select(lin),
        .chip_select_first_low(cs1_n), .chip_select_high_and_second_low(cs2),
        .output_drive_enable_n(oe_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

    // ================================================================
    // helpers
    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc();
        @(posedge core_clk);
        #1;
    endtask

    // address of burst step i from base a
    function automatic logic [16:0] ba(input logic [16:0] a, input int i, input logic l);
        logic [1:0] k;
        k = i[1:0];
        return {a[16:2], l ? a[1:0] + k : a[1:0] ^ k};
    endfunction

    // ================================================================
    // scenarios
    task automatic wr_burst(input logic [16:0] a, input logic l, input int n);
        logic [35:0] d;
        lin = l;
        bus_master_model_i.drive(1'b1, 1'b0, 1'b0, a, 1'b0, 36'h0);
        cyc();
        for (int i = 0; i < n; i++) begin
            d = 36'h9a5c30000 + 36'(i * 17) + {19'h0, a};
            mem[ba(a, i, l)] = d;
            check("dq_oe in write", {35'h0, dq_oe}, 36'h0);
            bus_master_model_i.drive(i < n - 1, i < n - 1, 1'b0, 17'h1ffff, 1'b1, d);
            cyc();
        end
        $display("done write burst");
    endtask

    task automatic rd_burst(input logic [16:0] a, input logic l, input int n,
                            input logic chained, input logic nxt_on, input logic [16:0] nxt);
        lin = l;
        if (!chained) begin
            bus_master_model_i.drive(1'b1, 1'b0, 1'b1, a, 1'b0, 36'h0);
            cyc();
        end
        for (int i = 0; i < n; i++) begin
            check("dq_out in read", dq_out, mem[ba(a, i, l)]);
            check("dq_oe in read", {35'h0, dq_oe}, 36'h1);
            if (i < n - 1)
                bus_master_model_i.drive(1'b0, 1'b1, 1'b0, ~a, 1'b0, 36'h0);
            else
                bus_master_model_i.drive(nxt_on, 1'b0, 1'b1, nxt, 1'b0, 36'h0);
            cyc();
        end
        if (!nxt_on) begin
            check("dq_oe after deselect", {35'h0, dq_oe}, 36'h0);
            // noop while idle must not restart the read
            bus_master_model_i.drive(1'b0, 1'b1, 1'b1, nxt, 1'b0, 36'h0);
            cyc();
            check("dq_oe in noop", {35'h0, dq_oe}, 36'h0);
        end
        $display("done read burst");
    endtask

    task automatic suspend_read(input logic [16:0] a);
        lin = 1'b1;
        bus_master_model_i.drive(1'b1, 1'b0, 1'b1, a, 1'b0, 36'h0);
        cyc();
        check("dq_out first word", dq_out, mem[a]);
        bus_master_model_i.hold_off();
        cyc();
        check("dq_out held", dq_out, mem[a]);
        // output enable held high across the second suspended edge
        oe_n = 1'b1;
        #1;
        check("dq_oe gated", {35'h0, dq_oe}, 36'h0);
        cyc();
        check("dq_out after suspend", dq_out, mem[a]);
        oe_n = 1'b0;
        bus_master_model_i.drive(1'b0, 1'b1, 1'b0, 17'h0, 1'b0, 36'h0);
        #1;
        check("dq_oe ungated", {35'h0, dq_oe}, 36'h1);
        cyc();
        check("dq_out next word", dq_out, mem[ba(a, 1, 1'b1)]);
        bus_master_model_i.drive(1'b0, 1'b0, 1'b0, 17'h0, 1'b0, 36'h0);
        cyc();
        check("dq_oe stop", {35'h0, dq_oe}, 36'h0);
        $display("done suspend read");
    endtask

    task automatic turnaround(input logic [16:0] a, input logic [35:0] d);
        bus_master_model_i.drive(1'b1, 1'b0, 1'b0, a, 1'b0, 36'h0);
        cyc();
        mem[a] = d;
        bus_master_model_i.drive(1'b1, 1'b0, 1'b1, a, 1'b1, d);
        cyc();
        check("dq_out turnaround", dq_out, d);
        // lanes 1 and 3 take the inverse, lanes 0 and 2 keep the old word
        bus_master_model_i.drive(1'b1, 1'b0, 1'b0, a, 1'b0, 36'h0, 4'h5);
        cyc();
        check("dq_oe in write data cycle", {35'h0, dq_oe}, 36'h0);
        mem[a] = d ^ 36'haff00ff00;
        bus_master_model_i.drive(1'b1, 1'b0, 1'b1, a, 1'b1, ~d);
        cyc();
        check("dq_out partial lanes", dq_out, mem[a]);
        bus_master_model_i.drive(1'b0, 1'b0, 1'b0, a, 1'b0, 36'h0);
        cyc();
        $display("done turnaround");
    endtask

    // ================================================================
    // verdict and end of run
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ================================================================
    // main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        #1;
        rst = 1'b0;
        wr_burst(17'h000a5, 1'b1, 5);
        wr_burst(17'h01237, 1'b1, 4);
        rd_burst(17'h000a5, 1'b1, 5, 1'b0, 1'b1, 17'h01237);
        rd_burst(17'h01237, 1'b0, 4, 1'b1, 1'b0, 17'h0);
        suspend_read(17'h000a5);
        turnaround(17'h1fffe, 36'h5c3a96e01);
        conclude();
    end
endmodule

/* rtl/burst_counter.sv */
// two-bit burst counter with linear and interleaved order
// assumes load and advance are never high together
`timescale 1ns/1ps
`include "sram_port_defines.svh"

module burst_counter (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // control view
    burst_if.cnt bus
);

    sram_port_pkg::burst_t base_reg;
    sram_port_pkg::burst_t base_next;
    sram_port_pkg::burst_t cnt_reg;
    sram_port_pkg::burst_t cnt_next;

    // ================================================================
    // order mapping: sum for linear, xor for interleaved
    function automatic sram_port_pkg::burst_t order_map(
        input sram_port_pkg::burst_t b,
        input sram_port_pkg::burst_t c,
        input logic lin
    );
        order_map = lin ? sram_port_pkg::burst_t'(b + c) : (b ^ c);
    endfunction

    // next base and step count, count wraps after the fourth
    always_comb begin
        base_next = base_reg;
        cnt_next = cnt_reg;
        if (bus.load) begin
            base_next = bus.base;
            cnt_next = `BURST_CNT_RST;
        end else if (bus.advance) begin
            cnt_next = sram_port_pkg::burst_t'(cnt_reg + 2'h1);
        end
    end

    // register counter state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            base_reg <= `BURST_CNT_RST;
            cnt_reg <= `BURST_CNT_RST;
        end else begin
            base_reg <= base_next;
            cnt_reg <= cnt_next;
        end
    end

    // current and coming low address bits
    assign bus.cur = order_map(base_reg, cnt_reg, bus.linear);
    assign bus.nxt = order_map(base_next, cnt_next, bus.linear);

endmodule

/* rtl/burst_if.sv */
// signals between the port control and its burst counter
// assumes one clock domain, driven by sync_burst_sram_port
`timescale 1ns/1ps
`include "sram_port_defines.svh"

interface burst_if;
    logic load;
    logic advance;
    logic linear;
    sram_port_pkg::burst_t base;
    sram_port_pkg::burst_t cur;
    sram_port_pkg::burst_t nxt;

    // ================================================================
    // views
    modport ctl (output load, output advance, output linear, output base,
                 input cur, input nxt);
    modport cnt (input load, input advance, input linear, input base,
                 output cur, output nxt);
endinterface

/* rtl/sram_port_defines.svh */
// widths, reset values and burst figures of the synchronous burst sram port
// assumes inclusion by bare name from package and modules
`ifndef SRAM_PORT_DEFINES_SVH
`define SRAM_PORT_DEFINES_SVH

// ====================================================================
// array shape
`define SRAM_ADDR_W 17
`define SRAM_DATA_W 36
`define SRAM_BYTES 4
`define SRAM_BYTE_W 8
`define SRAM_PAR_BASE 32
`define SRAM_DEPTH 131072

// ====================================================================
// burst counter
`define BURST_W 2
`define BURST_CNT_RST 2'h0

// ====================================================================
// reset values
`define RD_DATA_RST 36'h0
`define BYTE_EN_RST 4'hf
`define ADDR_HI_RST 15'h0

`endif

/* rtl/sram_port_pkg.sv */
// types shared by the burst sram port and its counter
// assumes sram_port_defines.svh on the include path
`include "sram_port_defines.svh"

package sram_port_pkg;

    // ================================================================
    // types
    typedef logic [`SRAM_ADDR_W-1:0] addr_t;
    typedef logic [`SRAM_DATA_W-1:0] word_t;
    typedef logic [`BURST_W-1:0] burst_t;

    // operation owning the coming data cycle
    typedef enum logic [1:0] {
        OP_IDLE  = 2'b00,
        OP_READ  = 2'b01,
        OP_WRITE = 2'b10
    } op_e;

endpackage

/* rtl/sync_burst_sram_port.sv */
// synchronous burst sram port, 128k words of 36 bits, flow-through reads
// assumes all inputs synchronous to core_clk; bidirectional data is split
`timescale 1ns/1ps
`include "sram_port_defines.svh"

module sync_burst_sram_port (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // address and control
    input wire logic [`SRAM_ADDR_W-1:0] address,
    input wire logic read_write_select,
    input wire logic step_or_capture,
    input wire logic clock_gate_low,
    input wire logic [`SRAM_BYTES-1:0] byte_lane_strobes_n,
    input wire logic linear_order_select,
    // chip selects, [1] active high, [0] active low
    input wire logic chip_select_first_low,
    input wire logic [1:0] chip_select_high_and_second_low,
    // data pins
    input wire logic output_drive_enable_n,
    input wire logic [`SRAM_DATA_W-1:0] dq_in,
    output logic [`SRAM_DATA_W-1:0] dq_out,
    output logic dq_oe
);

    localparam int HI_W = `SRAM_ADDR_W - `BURST_W;

    // ================================================================
    // storage and state
    sram_port_pkg::word_t mem [0:`SRAM_DEPTH-1];
    sram_port_pkg::op_e op_reg;
    sram_port_pkg::op_e op_next;
    logic [HI_W-1:0] hi_reg;
    logic [HI_W-1:0] hi_next;
    logic [`SRAM_BYTES-1:0] be_reg;
    logic [`SRAM_BYTES-1:0] be_next;
    sram_port_pkg::word_t rd_data_reg;
    sram_port_pkg::word_t rd_data_next;

    logic en;
    logic sel;
    logic start;
    logic adv;
    logic wr_do;
    sram_port_pkg::addr_t eff_addr;
    sram_port_pkg::addr_t next_addr;
    sram_port_pkg::word_t mem_cur;
    sram_port_pkg::word_t wr_word;

    // assertion clock and reset for the whole module
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    burst_if bus ();

    burst_counter u_counter (
        .core_clk (core_clk),
        .rst (rst),
        .bus (bus)
    );

    // ================================================================
    // cycle decode
    assign en = !clock_gate_low;
    assign sel = !chip_select_first_low && chip_select_high_and_second_low[1]
                 && !chip_select_high_and_second_low[0];
    assign start = en && !step_or_capture && sel;
    // advance only while a burst is live; rw and address ignored
    assign adv = en && step_or_capture && (op_reg != sram_port_pkg::OP_IDLE);
    assign wr_do = en && (op_reg == sram_port_pkg::OP_WRITE);

    // counter hookup
    assign bus.load = start;
    assign bus.advance = adv;
    assign bus.base = address[`BURST_W-1:0];
    assign bus.linear = linear_order_select;

    // data-cycle address and the one for the coming cycle
    assign eff_addr = {hi_reg, bus.cur};
    assign next_addr = {hi_next, bus.nxt};
    assign mem_cur = mem[eff_addr];

    // ================================================================
    // byte merge of write data into the stored word
    for (genvar k = 0; k < `SRAM_BYTES; k++) begin : g_lane
        assign wr_word[`SRAM_BYTE_W*k +: `SRAM_BYTE_W] = be_reg[k] ?
            mem_cur[`SRAM_BYTE_W*k +: `SRAM_BYTE_W] :
            dq_in[`SRAM_BYTE_W*k +: `SRAM_BYTE_W];
        assign wr_word[`SRAM_PAR_BASE + k] = be_reg[k] ?
            mem_cur[`SRAM_PAR_BASE + k] : dq_in[`SRAM_PAR_BASE + k];
    end

    // ================================================================
    // next operation, address and strobes
    always_comb begin
        op_next = op_reg;
        hi_next = hi_reg;
        be_next = be_reg;
        if (en) begin
            be_next = byte_lane_strobes_n;
            if (!step_or_capture) begin
                if (sel) begin
                    // direction latched here only
                    op_next = read_write_select ? sram_port_pkg::OP_READ :
                              sram_port_pkg::OP_WRITE;
                    hi_next = address[`SRAM_ADDR_W-1:`BURST_W];
                end else begin
                    op_next = sram_port_pkg::OP_IDLE;
                end
            end
        end
    end

    // read data for the coming cycle, forwarding a same-edge write
    always_comb begin
        rd_data_next = rd_data_reg;
        if (en && (op_next == sram_port_pkg::OP_READ)) begin
            case ({wr_do, next_addr == eff_addr})
                2'b11: begin
                    rd_data_next = wr_word;
                end
                default: begin
                    rd_data_next = mem[next_addr];
                end
            endcase
        end
    end

    // register control state
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            op_reg <= sram_port_pkg::OP_IDLE;
            hi_reg <= `ADDR_HI_RST;
            be_reg <= `BYTE_EN_RST;
            rd_data_reg <= `RD_DATA_RST;
        end else begin
            op_reg <= op_next;
            hi_reg <= hi_next;
            be_reg <= be_next;
            rd_data_reg <= rd_data_next;
        end
    end

    // array write of the pending word, also done across a deselect
    always_ff @(posedge core_clk) begin
        if (wr_do) begin
            mem[eff_addr] <= wr_word;
        end
    end

    // ================================================================
    // pin drive: read cycles only, gated by output enable
    assign dq_out = rd_data_reg;
    assign dq_oe = (op_reg == sram_port_pkg::OP_READ) && !output_drive_enable_n;

    // ================================================================
    // checks
    sequence load_rd_s;
        en && !step_or_capture && sel && read_write_select;
    endsequence

    sequence live_adv_s;
        en && step_or_capture && (op_reg != sram_port_pkg::OP_IDLE);
    endsequence

    sequence four_adv_s;
        live_adv_s ##1 (en && step_or_capture)[*3];
    endsequence

    read_latency_a: assert property (load_rd_s |=>
        (op_reg == sram_port_pkg::OP_READ) && (eff_addr == $past(address)))
        else $error("load read not owning next data cycle");

    burst_write_a: assert property (
        (en && step_or_capture && (op_reg == sram_port_pkg::OP_WRITE)) |=>
        (op_reg == sram_port_pkg::OP_WRITE) && (be_reg == $past(byte_lane_strobes_n))
        && (eff_addr[HI_W+1:2] == $past(eff_addr[HI_W+1:2])))
        else $error("burst write lost its direction or strobes");

    burst_step_a: assert property (live_adv_s |=>
        (eff_addr[1:0] != $past(eff_addr[1:0])) &&
        (eff_addr[HI_W+1:2] == $past(eff_addr[HI_W+1:2])))
        else $error("burst counter did not advance");

    back_to_back_a: assert property (
        ((op_reg != sram_port_pkg::OP_IDLE) && en && !step_or_capture && sel) |=>
        (eff_addr == $past(address)) && (op_reg != sram_port_pkg::OP_IDLE))
        else $error("load after burst not taken at once");

    suspend_hold_a: assert property (!en |=>
        $stable(dq_out) && $stable(op_reg) && $stable(eff_addr))
        else $error("suspended edge changed state");

    suspend_read_a: assert property ((load_rd_s ##1 !en) |=>
        (op_reg == sram_port_pkg::OP_READ) && $stable(dq_out))
        else $error("read lost across suspended cycle");

    deselect_float_a: assert property (
        (en && !step_or_capture && !sel) |=> !dq_oe ##0 !wr_do)
        else $error("bus not floated after deselect");

    dir_fixed_a: assert property (live_adv_s |=> op_reg == $past(op_reg))
        else $error("burst direction changed while advancing");

    burst_wrap_a: assert property (four_adv_s |=>
        eff_addr[1:0] == $past(eff_addr[1:0], 4))
        else $error("burst counter did not wrap after four");

    oe_gate_a: assert property (output_drive_enable_n |-> !dq_oe)
        else $error("data driven with output enable high");

endmodule
